// File: smx_pkg.sv
// Constants shared by the status monitor output multiplexer
package smx_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Clock and pulse timing
  localparam int CLK_MHZ = 200;
  localparam int QUAD_DONE_NS = 480;
  localparam int FILT_READY_NS = 65;
  localparam int QUAD_DONE_CYC = (QUAD_DONE_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_READY_CYC = (FILT_READY_NS * CLK_MHZ + 999) / 1000;
  localparam int ADC_READY_CYC = 1;
  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  // Control register fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_FAST_BIT = 8;
  localparam int CTRL_FREEZE_BIT = 9;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic FAST_RESET = 1'b0;
  localparam logic FREEZE_RESET = 1'b0;
  // Status register fields
  localparam int STAT_PINS_LSB = 0;
  localparam int STAT_FROZEN_BIT = 8;
  localparam int STAT_SAT_LSB = 9;
  localparam logic [7:0] PINS_RESET = 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // Selector codes
  localparam logic [7:0] SEL_CAL_ENABLE = 8'h0B;
  localparam logic [7:0] SEL_GAIN_FLAGS = 8'h0C;
  localparam logic [7:0] SEL_QUAD_RF = 8'h0D;
  localparam logic [7:0] SEL_BB_CAL = 8'h0E;
  localparam logic [7:0] SEL_RX1_STATE = 8'h0F;
  localparam logic [7:0] SEL_RX2_STATE = 8'h10;
  localparam logic [7:0] SEL_AUX_RESULT = 8'h11;
  localparam logic [7:0] SEL_RX1_POWER = 8'h12;
  localparam logic [7:0] SEL_RX2_POWER = 8'h13;
endpackage : smx_pkg

// File: smx_pulse_stretch.sv
// Stretches a one-cycle event to a fixed number of clock cycles
`timescale 1ns/10ps
module smx_pulse_stretch #(
  parameter int WIDTH_CYC = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Event in, stretched level out
  input wire logic pulse_in,
  output logic pulse_out
);
  localparam int CW = $clog2(WIDTH_CYC + 1);
  localparam logic [CW-1:0] LOAD = CW'(WIDTH_CYC);

  generate
    if (WIDTH_CYC < 1) begin : g_bad
      $error("smx_pulse_stretch needs WIDTH_CYC of at least one");
    end
  endgenerate

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  // A new event restarts the count, so back-to-back events merge
  assign cnt_next = pulse_in ? LOAD : ((cnt_reg != '0) ? cnt_reg - CW'(1) : cnt_reg);
  assign pulse_out = (cnt_reg != '0);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : smx_pulse_stretch

// File: smx_sat_flag.sv
// Sticky digital saturation flag for one receive channel
`timescale 1ns/10ps
module smx_sat_flag (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Channel conditions
  input wire logic overload,
  input wire logic gain_change,
  input wire logic peak_reset,
  // Flag
  output logic sat_flag
);
  logic flag_reg;
  logic flag_next;

  // Gain change clears; detection is blind while peak detectors sit in reset
  assign flag_next = gain_change ? 1'b0 : ((overload && !peak_reset) ? 1'b1 : flag_reg);
  assign sat_flag = flag_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end
endmodule : smx_sat_flag

// File: smx_monitor_mux.sv
// Status monitor multiplexer driving the eight control output pins
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps

// Notes on behaviour
// - 0x0B: sequencer state high, enable state low
// - Baseband offset calibration shows sequencer state 0x2
// - Alert state reports enable state five
// - 0x0C: energy-lost flags on pins seven, five
// - 0x0C: peak reset flags on pins six, four
// - 0x0C: pin three frozen gain, only after lock
// - Saturation flag sticky until gain changes
// - Saturation cannot set during peak detector reset
// - 0x0D: quadrature calibration states on two pin pairs
// - 0x0D: quadrature done pulse, about 480 ns
// - 0x0D: pin four RF offset calibration active
// - 0x0E: pin four baseband or RF calibration
// - 0x0F: Rx1 gain state, peak resets, RF state
// - 0x10: Rx2 gain state, strength valid, RF state
// - 0x11: converter result bits eleven to four
// - 0x12: filter power ready pulse, about 65 ns
// - 0x12: converter power ready pulse per word
// - 0x12: Rx1 lock, lost, stronger, gain state
// - 0x13: same groups mirrored for Rx2
// - Energy lost only in fast mode, level
// - Gain lock only in fast mode, level
// - Slow mode gain state never sets top bit
// - Stronger signal only in fast mode, level
module smx_monitor_mux
  import smx_pkg::*;
#(
  // Pulse widths in cycles; defaults round the profile times up
  parameter int QUAD_DONE_WIDTH = QUAD_DONE_CYC,
  parameter int FILT_READY_WIDTH = FILT_READY_CYC,
  parameter int CONV_READY_WIDTH = ADC_READY_CYC
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Calibration and enable state machines
  input wire logic [3:0] CAL_SEQ_STATE,
  input wire logic [3:0] ENABLE_STATE_MACHINE_STATE,
  input wire logic RF_OFFSET_CALIBRATION_ACTIVE,
  input wire logic BASEBAND_OFFSET_CALIBRATION_ACTIVE,
  // Transmit quadrature calibration, bit 0 Tx1, bit 1 Tx2
  input wire logic [1:0] QUAD_CAL_STATE_TX1,
  input wire logic [1:0] QUAD_CAL_STATE_TX2,
  input wire logic [1:0] QUAD_CAL_DONE,
  // Receive gain control, bit 0 Rx1, bit 1 Rx2
  input wire logic [2:0] AUTO_GAIN_STATE_RX1,
  input wire logic [2:0] AUTO_GAIN_STATE_RX2,
  input wire logic [1:0] GAIN_LOCK,
  input wire logic [1:0] ENERGY_LOST,
  input wire logic [1:0] STRONGER_SIGNAL,
  input wire logic [1:0] PEAK_RESET,
  input wire logic [1:0] DIGITAL_OVERLOAD,
  input wire logic [1:0] GAIN_CHANGE,
  input wire logic [1:0] SIGNAL_STRENGTH_VALID,
  input wire logic [1:0] FILTER_POWER_EVENT,
  input wire logic [1:0] CONVERTER_POWER_EVENT,
  input wire logic [1:0] CONVERTER_POWER_FOR_GAIN,
  // Receive RF offset calibration states
  input wire logic [1:0] RF_OFFSET_CALIBRATION_STATE_RX1,
  input wire logic [1:0] RF_OFFSET_CALIBRATION_STATE_RX2,
  // Auxiliary converter
  input wire logic [11:0] AUXILIARY_CONVERTER_RESULT,
  // Monitor pins
  output logic [7:0] CTRL_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks
  // A zero width would hide a pulse from the observer
  generate
    if (QUAD_DONE_WIDTH < 1) begin : g_bad_quad
      $error("smx_monitor_mux needs QUAD_DONE_WIDTH of at least one");
    end
    if (FILT_READY_WIDTH < 1) begin : g_bad_filt
      $error("smx_monitor_mux needs FILT_READY_WIDTH of at least one");
    end
    if (CONV_READY_WIDTH < 1) begin : g_bad_conv
      $error("smx_monitor_mux needs CONV_READY_WIDTH of at least one");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone register access
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [7:0] sel_reg;
  logic fast_reg;
  logic freeze_req_reg;
  logic frozen_reg;
  logic [7:0] pins_reg;
  logic [7:0] pins_next;
  logic [1:0] sat_flag;
  logic [31:0] rdata_next;

  // One request per ack; a strobe held on is not taken twice
  wire req = WB_CYC_I && WB_STB_I && !ack_reg;
  wire hit_ctrl = (WB_ADR_I == CTRL_OFFSET);
  wire hit_status = (WB_ADR_I == STATUS_OFFSET);
  // Writes land on the edge the master samples ack, while its request still stands
  wire wr_take = WB_CYC_I && WB_STB_I && ack_reg && WB_WE_I;
  wire wr_ctrl = wr_take && hit_ctrl;
  wire wr_byte0 = wr_ctrl && WB_SEL_I[0];
  wire wr_byte1 = wr_ctrl && WB_SEL_I[1];

  wire [31:0] ctrl_view = {22'h00_0000, freeze_req_reg, fast_reg, sel_reg};
  // Frozen and both saturation flags sit above the pins
  wire [31:0] status_view = {21'h00_0000, sat_flag, frozen_reg, pins_reg};

  // Unmapped addresses still answer, reading zero and dropping writes
  assign rdata_next = hit_ctrl ? ctrl_view : (hit_status ? status_view : 32'h0000_0000);
  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdata_reg;

  // Registered ack costs a wait state but keeps decode off the bus path
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      rdata_reg <= req ? rdata_next : rdata_reg;
    end
  end

  // Selector and mode bits
  always_ff @(posedge MCLK) begin
    if (RST) begin
      sel_reg <= SEL_RESET;
      fast_reg <= FAST_RESET;
      freeze_req_reg <= FREEZE_RESET;
    end else begin
      if (wr_byte0) begin
        sel_reg <= WB_DAT_I[CTRL_SEL_LSB +: 8];
      end
      if (wr_byte1) begin
        fast_reg <= WB_DAT_I[CTRL_FAST_BIT];
        freeze_req_reg <= WB_DAT_I[CTRL_FREEZE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gain freeze
  // A request before lock waits; once frozen it holds until withdrawn
  wire any_lock = fast_reg && (GAIN_LOCK != 2'b00);
  wire frozen_next = freeze_req_reg && (frozen_reg || any_lock);

  always_ff @(posedge MCLK) begin
    if (RST) begin
      frozen_reg <= 1'b0;
    end else begin
      frozen_reg <= frozen_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per channel flag conditioning
  logic [1:0] lock_flag;
  logic [1:0] lost_flag;
  logic [1:0] strong_flag;
  logic [1:0] filt_ready;
  logic [1:0] conv_ready;
  logic [1:0] quad_done;

  // Pin map fixes two receive and two transmit channels
  localparam int NUM_CH = 2;
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
      // Fast mode only; the slow controller has no such conditions
      assign lock_flag[ch] = fast_reg && GAIN_LOCK[ch];
      assign lost_flag[ch] = fast_reg && ENERGY_LOST[ch];
      assign strong_flag[ch] = fast_reg && STRONGER_SIGNAL[ch];

      smx_sat_flag u_sat (
        .clk(MCLK),
        .rst(RST),
        .overload(DIGITAL_OVERLOAD[ch]),
        .gain_change(GAIN_CHANGE[ch]),
        .peak_reset(PEAK_RESET[ch]),
        .sat_flag(sat_flag[ch])
      );

      smx_pulse_stretch #(
        .WIDTH_CYC(FILT_READY_WIDTH)
      ) u_filt (
        .clk(MCLK),
        .rst(RST),
        .pulse_in(FILTER_POWER_EVENT[ch]),
        .pulse_out(filt_ready[ch])
      );

      // Only meaningful while converter power feeds gain control
      wire conv_event = CONVERTER_POWER_EVENT[ch] && CONVERTER_POWER_FOR_GAIN[ch];
      smx_pulse_stretch #(
        .WIDTH_CYC(CONV_READY_WIDTH)
      ) u_conv (
        .clk(MCLK),
        .rst(RST),
        .pulse_in(conv_event),
        .pulse_out(conv_ready[ch])
      );

      smx_pulse_stretch #(
        .WIDTH_CYC(QUAD_DONE_WIDTH)
      ) u_quad (
        .clk(MCLK),
        .rst(RST),
        .pulse_in(QUAD_CAL_DONE[ch]),
        .pulse_out(quad_done[ch])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Gain state fields
  // Slow controller has four states; mask the top bit against stray values
  wire [2:0] gain_state_rx1 = fast_reg ? AUTO_GAIN_STATE_RX1 : {1'b0, AUTO_GAIN_STATE_RX1[1:0]};
  wire [2:0] gain_state_rx2 = fast_reg ? AUTO_GAIN_STATE_RX2 : {1'b0, AUTO_GAIN_STATE_RX2[1:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Pin groups, one per selector code
  // States pass through unchanged: calibration 0x2, alert 5
  wire [7:0] grp_cal_enable = {CAL_SEQ_STATE, ENABLE_STATE_MACHINE_STATE};

  wire [7:0] grp_gain_flags = {
    lost_flag[0],
    PEAK_RESET[0],
    lost_flag[1],
    PEAK_RESET[1],
    frozen_reg,
    sat_flag[0],
    sat_flag[1],
    1'b0
  };

  wire [7:0] grp_quad_rf = {
    QUAD_CAL_STATE_TX1,
    quad_done[0],
    RF_OFFSET_CALIBRATION_ACTIVE,
    QUAD_CAL_STATE_TX2,
    quad_done[1],
    1'b0
  };

  // Any offset calibration, baseband or RF, raises the pin
  wire offset_cal_any = BASEBAND_OFFSET_CALIBRATION_ACTIVE || RF_OFFSET_CALIBRATION_ACTIVE;
  wire [7:0] grp_bb_cal = {3'b000, offset_cal_any, 4'h0};

  wire [7:0] grp_rx1_state = {
    gain_state_rx1,
    PEAK_RESET[0],
    PEAK_RESET[1],
    RF_OFFSET_CALIBRATION_STATE_RX1,
    1'b0
  };

  wire [7:0] grp_rx2_state = {
    gain_state_rx2,
    SIGNAL_STRENGTH_VALID[1],
    SIGNAL_STRENGTH_VALID[0],
    RF_OFFSET_CALIBRATION_STATE_RX2,
    1'b0
  };

  wire [7:0] grp_aux = AUXILIARY_CONVERTER_RESULT[11:4];

  wire [7:0] grp_rx1_power = {
    filt_ready[0],
    lock_flag[0],
    lost_flag[0],
    strong_flag[0],
    conv_ready[0],
    gain_state_rx1
  };

  wire [7:0] grp_rx2_power = {
    filt_ready[1],
    lock_flag[1],
    lost_flag[1],
    strong_flag[1],
    conv_ready[1],
    gain_state_rx2
  };

  ////////////////////////////////////////////////////////////////////////////
  // Selection
  wire is_cal = (sel_reg == SEL_CAL_ENABLE);
  wire is_gain = (sel_reg == SEL_GAIN_FLAGS);
  wire is_quad = (sel_reg == SEL_QUAD_RF);
  wire is_bb = (sel_reg == SEL_BB_CAL);
  wire is_rx1s = (sel_reg == SEL_RX1_STATE);
  wire is_rx2s = (sel_reg == SEL_RX2_STATE);
  wire is_aux = (sel_reg == SEL_AUX_RESULT);
  wire is_rx1p = (sel_reg == SEL_RX1_POWER);
  wire is_rx2p = (sel_reg == SEL_RX2_POWER);

  // Exact compares, so a stray code can never mix two groups
  // Codes outside this block's range drive every pin low
  assign pins_next =
    is_cal ? grp_cal_enable :
    is_gain ? grp_gain_flags :
    is_quad ? grp_quad_rf :
    is_bb ? grp_bb_cal :
    is_rx1s ? grp_rx1_state :
    is_rx2s ? grp_rx2_state :
    is_aux ? grp_aux :
    is_rx1p ? grp_rx1_power :
    is_rx2p ? grp_rx2_power :
    8'h00;

  // One register stage so all pins change on the same edge
  // Costs a cycle of latency, but the pins never glitch
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pins_reg <= PINS_RESET;
    end else begin
      pins_reg <= pins_next;
    end
  end

  // Pins come straight from flops, never from the mux
  assign CTRL_OUT = pins_reg;

endmodule : smx_monitor_mux

// File: smx_bbp_model.sv
// Baseband observer timing pulses on one monitor pin
`timescale 1ns/10ps
module smx_bbp_model (
  // Clock
  input wire logic clk,
  // Pins and the pin to time
  input wire logic [7:0] pins,
  input wire logic [2:0] idx,
  // Last width in cycles
  output logic [31:0] width,
  output logic seen
);
  logic [31:0] cnt_reg = 32'h0000_0000;
  // Counts whole cycles, so a one-cycle pulse is still seen
  always @(posedge clk) begin
    seen <= 1'b0;
    if (pins[idx]) begin
      cnt_reg <= cnt_reg + 1;
    end else if (cnt_reg != 0) begin
      width <= cnt_reg;
      seen <= 1'b1;
      cnt_reg <= 32'h0000_0000;
    end
  end
endmodule : smx_bbp_model

// File: smx_monitor_mux_chk.sv
// Port checks for the monitor multiplexer
`timescale 1ns/10ps
module smx_monitor_mux_chk
  import smx_pkg::*;
(
  // Clock, reset, bus
  input wire logic MCLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_ACK_O,
  // Sources
  input wire logic [3:0] CAL_SEQ_STATE,
  input wire logic [3:0] ENABLE_STATE_MACHINE_STATE,
  input wire logic RF_OFFSET_CALIBRATION_ACTIVE,
  input wire logic BASEBAND_OFFSET_CALIBRATION_ACTIVE,
  input wire logic [1:0] QUAD_CAL_STATE_TX1,
  input wire logic [1:0] QUAD_CAL_STATE_TX2,
  input wire logic [1:0] QUAD_CAL_DONE,
  input wire logic [2:0] AUTO_GAIN_STATE_RX1,
  input wire logic [1:0] GAIN_LOCK,
  input wire logic [1:0] ENERGY_LOST,
  input wire logic [1:0] STRONGER_SIGNAL,
  input wire logic [1:0] PEAK_RESET,
  input wire logic [1:0] RF_OFFSET_CALIBRATION_STATE_RX1,
  input wire logic [11:0] AUXILIARY_CONVERTER_RESULT,
  // Pins
  input wire logic [7:0] CTRL_OUT
);
  logic [7:0] sel_reg;
  logic [7:0] sel_d_reg;
  logic fast_reg;
  wire take = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O & (WB_ADR_I == CTRL_OFFSET);
  // Shadow selector kept from bus writes, no internal probes needed
  always_ff @(posedge MCLK) begin
    if (RST) begin
      sel_reg <= SEL_RESET;
      fast_reg <= FAST_RESET;
    end else if (take) begin
      sel_reg <= WB_DAT_I[7:0];
      fast_reg <= WB_DAT_I[CTRL_FAST_BIT];
    end
  end
  always_ff @(posedge MCLK) begin
    sel_d_reg <= sel_reg;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  //////////////////////////////////////////////////////////////////////////
  cal_enable_a: assert property (
    sel_d_reg == SEL_CAL_ENABLE |-> CTRL_OUT == $past({CAL_SEQ_STATE, ENABLE_STATE_MACHINE_STATE}))
    else $error("selector 0B pins wrong");
  gain_flags_a: assert property (
    sel_d_reg == SEL_GAIN_FLAGS |-> CTRL_OUT[7:4] == $past({ENERGY_LOST[0] & fast_reg, PEAK_RESET[0],
    ENERGY_LOST[1] & fast_reg, PEAK_RESET[1]})) else $error("selector 0C pins wrong");
  quad_rf_a: assert property (
    sel_d_reg == SEL_QUAD_RF |-> {CTRL_OUT[7:6], CTRL_OUT[4:2]} == $past({QUAD_CAL_STATE_TX1,
    RF_OFFSET_CALIBRATION_ACTIVE, QUAD_CAL_STATE_TX2})) else $error("selector 0D pins wrong");
  bb_cal_a: assert property (
    sel_d_reg == SEL_BB_CAL |-> CTRL_OUT == {3'h0, $past(BASEBAND_OFFSET_CALIBRATION_ACTIVE |
    RF_OFFSET_CALIBRATION_ACTIVE), 4'h0}) else $error("selector 0E pins wrong");
  rx1_state_a: assert property (
    sel_d_reg == SEL_RX1_STATE |-> CTRL_OUT[7:1] == $past({AUTO_GAIN_STATE_RX1[2] & fast_reg,
    AUTO_GAIN_STATE_RX1[1:0], PEAK_RESET[0], PEAK_RESET[1], RF_OFFSET_CALIBRATION_STATE_RX1}))
    else $error("selector 0F pins wrong");
  aux_result_a: assert property (
    sel_d_reg == SEL_AUX_RESULT |-> CTRL_OUT == $past(AUXILIARY_CONVERTER_RESULT[11:4]))
    else $error("selector 11 pins wrong");
  rx1_power_a: assert property (
    sel_d_reg == SEL_RX1_POWER |-> CTRL_OUT[6:4] == $past({GAIN_LOCK[0], ENERGY_LOST[0],
    STRONGER_SIGNAL[0]} & {3{fast_reg}})) else $error("selector 12 pins wrong");
  unused_sel_a: assert property (
    (sel_d_reg < SEL_CAL_ENABLE || sel_d_reg > SEL_RX2_POWER) |-> CTRL_OUT == 8'h00)
    else $error("unused selector drives pins");
  quad_done_a: assert property (
    sel_reg == SEL_QUAD_RF && QUAD_CAL_DONE[0] |-> ##2 CTRL_OUT[5] [*8])
    else $error("done pulse missing or short");
endmodule : smx_monitor_mux_chk
bind smx_monitor_mux smx_monitor_mux_chk i_chk (.*);

// File: test_smx_monitor_mux.sv
// Self-checking bench for the monitor multiplexer
`timescale 1ns/10ps
module test_smx_monitor_mux;
  import smx_pkg::*;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic armed = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [45:0] lv = '0;
  logic [5:0] pe = 6'h00;
  logic [1:0] ov = 2'h0;
  logic [1:0] gc = 2'h0;
  logic [1:0] pfg = 2'h3;
  logic [2:0] mbit = 3'h0;
  wire [31:0] rdat;
  wire [31:0] width;
  wire [7:0] pins;
  wire ack;
  wire seen;
  logic [31:0] exp_q[$];
  int fails = 0;
  int cmp_count = 0;
  int wid[3] = '{QUAD_DONE_CYC, FILT_READY_CYC, ADC_READY_CYC};
  logic [2:0] pbit[3] = '{3'h5, 3'h7, 3'h3};
  always #2.5 MCLK = ~MCLK;
  smx_monitor_mux i_dut (
    .MCLK(MCLK), .RST(RST), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .CAL_SEQ_STATE(lv[45:42]), .ENABLE_STATE_MACHINE_STATE(lv[41:38]),
    .RF_OFFSET_CALIBRATION_ACTIVE(lv[37]), .BASEBAND_OFFSET_CALIBRATION_ACTIVE(lv[36]),
    .QUAD_CAL_STATE_TX1(lv[35:34]), .QUAD_CAL_STATE_TX2(lv[33:32]), .QUAD_CAL_DONE(pe[5:4]),
    .AUTO_GAIN_STATE_RX1(lv[31:29]), .AUTO_GAIN_STATE_RX2(lv[28:26]), .GAIN_LOCK(lv[25:24]),
    .ENERGY_LOST(lv[23:22]), .STRONGER_SIGNAL(lv[21:20]), .PEAK_RESET(lv[19:18]),
    .DIGITAL_OVERLOAD(ov), .GAIN_CHANGE(gc), .SIGNAL_STRENGTH_VALID(lv[17:16]),
    .FILTER_POWER_EVENT(pe[3:2]), .CONVERTER_POWER_EVENT(pe[1:0]), .CONVERTER_POWER_FOR_GAIN(pfg),
    .RF_OFFSET_CALIBRATION_STATE_RX1(lv[15:14]), .RF_OFFSET_CALIBRATION_STATE_RX2(lv[13:12]),
    .AUXILIARY_CONVERTER_RESULT(lv[11:0]), .CTRL_OUT(pins));
  smx_bbp_model i_bbp (.clk(MCLK), .pins(pins), .idx(mbit), .width(width), .seen(seen));
  function automatic logic [7:0] exp_pins(input logic [7:0] s, input logic f);
    logic [2:0] g1;
    logic [2:0] g2;
    g1 = {lv[31] & f, lv[30:29]};
    g2 = {lv[28] & f, lv[27:26]};
    case (s)
      SEL_CAL_ENABLE: return lv[45:38];
      SEL_GAIN_FLAGS: return {lv[22] & f, lv[18], lv[23] & f, lv[19], 4'h0};
      SEL_QUAD_RF: return {lv[35:34], 1'b0, lv[37], lv[33:32], 2'h0};
      SEL_BB_CAL: return {3'h0, lv[36] | lv[37], 4'h0};
      SEL_RX1_STATE: return {g1, lv[18], lv[19], lv[15:14], 1'b0};
      SEL_RX2_STATE: return {g2, lv[17], lv[16], lv[13:12], 1'b0};
      SEL_AUX_RESULT: return lv[11:4];
      SEL_RX1_POWER: return {1'b0, lv[24] & f, lv[22] & f, lv[20] & f, 1'b0, g1};
      SEL_RX2_POWER: return {1'b0, lv[25] & f, lv[23] & f, lv[21] & f, 1'b0, g2};
      default: return 8'h00;
    endcase
  endfunction : exp_pins
  task automatic idle(input int n);
    repeat (n) @(posedge MCLK);
  endtask : idle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge MCLK);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic check(input logic [31:0] got);
    cmp_count++;
    if (exp_q.size() == 0 || got !== exp_q[0]) begin
      fails++;
      $display("unexpected at %0t: got %h", $time, got);
    end
    if (exp_q.size() != 0) exp_q.delete(0);
  endtask : check
  task automatic stop_test();
    if (exp_q.size() != 0) begin
      fails++;
      $display("unexpected at %0t: %0d results never seen", $time, exp_q.size());
    end
    $display("compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // Results are judged here, apart from the driver
  always @(posedge MCLK) begin
    if (ack === 1'b1 && we === 1'b0) check(rdat);
    if (seen === 1'b1 && armed === 1'b1) check(width);
  end
  initial begin
    repeat (20000) @(posedge MCLK);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end
  initial begin
    void'($urandom(48880));
    repeat (20) @(posedge MCLK);
    RST <= 1'b0;
    rd(CTRL_OFFSET, 32'h0000_0000);
    rd(8'h08, 32'h0000_0000);
    rd(STATUS_OFFSET, 32'h0000_0000);
    $display("test reset done");
    for (int f = 0; f < 2; f++) begin
      for (int s = 8'h0A; s <= 8'h14; s++) begin
        lv <= 46'({$urandom(), $urandom()});
        wb(1'b1, CTRL_OFFSET, 32'((f << CTRL_FAST_BIT) | s));
        idle(3);
        rd(STATUS_OFFSET, {24'h00_0000, exp_pins(8'(s), f[0])});
      end
    end
    $display("test select done");
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, CTRL_OFFSET, 32'h0000_0100 | 32'(i ? SEL_RX1_POWER : SEL_QUAD_RF));
      mbit <= pbit[i];
      idle(3);
      armed <= 1'b1;
      exp_q.push_back(32'(wid[i]));
      pe <= 6'h10 >> (2 * i);
      @(posedge MCLK);
      pe <= 6'h00;
      idle(wid[i] + 4);
      armed <= 1'b0;
    end
    @(posedge MCLK);
    pfg <= 2'h2;
    armed <= 1'b1;
    pe <= 6'h01;
    @(posedge MCLK);
    pe <= 6'h00;
    idle(6);
    armed <= 1'b0;
    pfg <= 2'h3;
    $display("test pulse done");
    lv <= '0;
    wb(1'b1, CTRL_OFFSET, 32'h0000_010C);
    ov <= 2'h1;
    idle(4);
    rd(STATUS_OFFSET, 32'h0000_0204);
    gc <= 2'h1;
    lv[18] <= 1'b1;
    @(posedge MCLK);
    gc <= 2'h0;
    idle(4);
    rd(STATUS_OFFSET, 32'h0000_0040);
    lv[18] <= 1'b0;
    idle(4);
    rd(STATUS_OFFSET, 32'h0000_0204);
    ov <= 2'h0;
    wb(1'b1, CTRL_OFFSET, 32'h0000_030C);
    idle(3);
    rd(STATUS_OFFSET, 32'h0000_0204);
    lv[24] <= 1'b1;
    idle(4);
    rd(STATUS_OFFSET, 32'h0000_030C);
    $display("test saturation done");
    RST <= 1'b1;
    idle(4);
    RST <= 1'b0;
    rd(CTRL_OFFSET, 32'h0000_0000);
    rd(STATUS_OFFSET, 32'h0000_0000);
    $display("test reset again done");
    idle(2);
    stop_test();
  end
endmodule : test_smx_monitor_mux
